/* hdl/adc_seq_consts.svh */
// Purpose: offsets, field positions, reset values and sizes of the A/D sequencer front end
// Assumes: 32-bit Avalon-MM register slave, byte addresses, 40 MHz logic clock
// Notes:   definitions only
`ifndef ADC_SEQ_CONSTS_SVH
`define ADC_SEQ_CONSTS_SVH

`define NUM_ADC         4
`define NUM_CH          8
`define NUM_CH_DIFF     4'h4
`define FIFO_DEPTH      64
`define FIFO_AW         6
`define FIFO_FULL_LVL   7'h40

// register byte offsets
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_DIV         8'h08
`define REG_NCONV       8'h0C
`define REG_ADC_CFG     8'h10
`define REG_FIFO_LVL    8'h14
`define REG_CONV_CNT    8'h18

// control register fields
`define CTRL_START      0
`define CTRL_STOP       1
`define CTRL_SRC        2
`define CTRL_PULL       4

// status register fields
`define STAT_ACTIVE     0
`define STAT_CONV_ERR   1
`define STAT_OVF_ERR    2
`define STAT_BUSY       3
`define STAT_FRAME      4

// per-device configuration byte
`define CFG_STRIDE      8
`define CFG_W           5

// conversion clock sources
`define SRC_INT         2'h0
`define SRC_EXT1        2'h1
`define SRC_EXT2        2'h2

// reset values
`define DIV_RESET       16'h0031
`define PULL_RESET      2'h0

`endif

/* hdl/adc_seq_pkg.sv */
// Purpose: types shared by the A/D sequencer front end
// Assumes: adc_seq_consts.svh supplies the sizes
// Notes:   packed structs carry the per-device ADC signals and the FIFO word
package adc_seq_pkg;

   typedef struct packed {
      logic       cnv;
      logic [2:0] chan;
      logic       diff;
   } adc_ctl_t;

   typedef struct packed {
      logic        done;
      logic [15:0] data;
   } adc_res_t;

   typedef struct packed {
      logic        last;
      logic [15:0] data;
   } seq_word_t;

   typedef struct packed {
      logic [2:0] cnt_m1;
      logic       diff;
      logic       seq;
   } adc_cfg_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONV,
      ST_WAIT,
      ST_PUSH
   } seq_state_t;

endpackage

/* hdl/adc_sequencer_gather.sv */
// Purpose: A/D sequencer front end: conversion pulses, data set gathering, FIFO
// Assumes: each ADC answers a cnv pulse with a done pulse carrying its 16-bit result
// Notes:   channel count and sequencer mode are latched per event and a change shows from the next event; input mode reaches the devices from cfg_ff at once
//
// The Avalon-MM register port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "adc_seq_consts.svh"

// Summary of operation
// - each ADC device is individually switched into sequencer mode
// - every clock event converts all active channels into one FIFO data set
// - channels of a device convert in ascending order, pulses made internally
// - all sequencer devices run in parallel, same channel at the same time
// - a data set must be fully in the FIFO before the next event
// - each device is single-ended with eight channels or differential with four
// - active channel count per device, always from channel zero upward
// - data set ordered by device, lowest first, then channel ascending
// - data sets leave for host memory through the DMA write path
// - number of conversions is set while the clock keeps running
// - conversion clock from internal divider or an external input
// - A/D sequencer is independent of the D/A sequencer
// - rear lines give two clock inputs and a frame trigger, own pull reference
// - each channel is sampled once per clock event
// - error flags for events while busy and for a full FIFO
// - any error stops the sequencer; its conversion pulses stop too, except that a busy event landing in ST_CONV lets the current set finish
// - last value of the final conversion event carries a marker
module adc_sequencer_gather (
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   input  wire logic [7:0]             avs_address,
   input  wire logic                   avs_read,
   input  wire logic                   avs_write,
   input  wire logic [31:0]            avs_writedata,
   output logic [31:0]                 avs_readdata,
   output logic                        avs_waitrequest,
   input  wire logic                   ext_clk1,
   input  wire logic                   ext_clk2,
   input  wire logic                   frame_trig,
   output logic [1:0]                  rear_pull_sel,
   output logic                        seq_tick,
   output adc_seq_pkg::adc_ctl_t       adc_ctl [`NUM_ADC],
   input  wire adc_seq_pkg::adc_res_t  adc_res [`NUM_ADC],
   output logic                        fifo_valid,
   input  wire logic                   fifo_ready,
   output adc_seq_pkg::seq_word_t      fifo_word
);
   import adc_seq_pkg::*;

   logic        ack_ff;
   logic [31:0] rdata_ff;
   logic [1:0]  src_ff;
   logic [1:0]  pull_ff;
   logic [15:0] div_ff;
   logic [15:0] nconv_ff;
   logic [31:0] cfg_ff;
   logic        run_ff;
   logic        conv_err_ff;
   logic        ovf_err_ff;
   logic [15:0] conv_cnt_ff;
   seq_state_t  state_ff;
   logic [2:0]  ch_ff;
   logic [1:0]  dev_ff;
   logic [2:0]  pc_ff;
   logic        final_ff;
   logic [31:0] lat_ff;
   logic [3:0]  cnv_ff;
   logic [6:0]  wr_ptr_ff;
   logic [6:0]  rd_ptr_ff;
   seq_word_t   fifo_mem [`FIFO_DEPTH];

   logic        acc;
   logic        take;
   logic        wr_take;
   logic [31:0] rd_mux;
   logic        start_req;
   logic        stop_req;
   logic        clr_conv;
   logic        clr_ovf;
   logic        tick;
   logic        frame_level;
   logic        any_seq;
   logic        ev;
   logic        accept;
   logic        is_final;
   logic        conv_err_evt;
   logic        ovf_evt;
   logic [3:0]  part_mask;
   logic [3:0]  done_v;
   logic [3:0]  max_cnt;
   logic        all_done;
   logic [15:0] smp_word [`NUM_ADC];
   adc_cfg_t    cur;
   logic        last_in_dev;
   logic        later;
   logic        push;
   logic [6:0]  fifo_cnt;
   logic        fifo_full;

   function automatic adc_cfg_t cfg_of(input logic [31:0] v, input int d);
      cfg_of = adc_cfg_t'(v[d*`CFG_STRIDE +: `CFG_W]);
   endfunction

   // differential mode offers only four channel pairs
   function automatic logic [3:0] eff_cnt(input adc_cfg_t c);
      logic [3:0] n;
      n = {1'b0, c.cnt_m1} + 4'h1;
      if (c.diff && (n > `NUM_CH_DIFF)) begin
         n = `NUM_CH_DIFF;
      end
      eff_cnt = n;
   endfunction

   function automatic logic later_seq(input logic [31:0] v, input logic [1:0] d);
      later_seq = 1'b0;
      for (int i = 0; i < `NUM_ADC; i++) begin
         if ((i > int'(d)) && cfg_of(v, i).seq) begin
            later_seq = 1'b1;
         end
      end
   endfunction

   // ---- Avalon-MM slave: every access waits exactly one cycle
   assign acc             = avs_read | avs_write;
   assign avs_waitrequest = acc & ~ack_ff;
   assign take            = acc & ack_ff;
   assign wr_take         = take & avs_write;
   assign avs_readdata    = rdata_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= acc & ~ack_ff;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (avs_address)
         `REG_CTRL: begin
            rd_mux[`CTRL_SRC +: 2]  = src_ff;
            rd_mux[`CTRL_PULL +: 2] = pull_ff;
         end
         `REG_STATUS: begin
            rd_mux[`STAT_ACTIVE]   = run_ff;
            rd_mux[`STAT_CONV_ERR] = conv_err_ff;
            rd_mux[`STAT_OVF_ERR]  = ovf_err_ff;
            rd_mux[`STAT_BUSY]     = (state_ff != ST_IDLE);
            rd_mux[`STAT_FRAME]    = frame_level;
         end
         `REG_DIV:      rd_mux[15:0] = div_ff;
         `REG_NCONV:    rd_mux[15:0] = nconv_ff;
         `REG_ADC_CFG:  rd_mux = cfg_ff;
         `REG_FIFO_LVL: rd_mux[6:0] = fifo_cnt;
         `REG_CONV_CNT: rd_mux[15:0] = conv_cnt_ff;
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdata_ff <= 32'h0000_0000;
      end else if (avs_read && !ack_ff) begin
         rdata_ff <= rd_mux;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         src_ff   <= `SRC_INT;
         pull_ff  <= `PULL_RESET;
         div_ff   <= `DIV_RESET;
         nconv_ff <= 16'h0000;
         cfg_ff   <= 32'h0000_0000;
      end else if (wr_take) begin
         unique case (avs_address)
            `REG_CTRL: begin
               src_ff  <= avs_writedata[`CTRL_SRC +: 2];
               pull_ff <= avs_writedata[`CTRL_PULL +: 2];
            end
            `REG_DIV:     div_ff   <= avs_writedata[15:0];
            `REG_NCONV:   nconv_ff <= avs_writedata[15:0];
            `REG_ADC_CFG: cfg_ff   <= avs_writedata;
            default: ;
         endcase
      end
   end

   assign rear_pull_sel = pull_ff;
   assign start_req = wr_take && (avs_address == `REG_CTRL) && avs_writedata[`CTRL_START];
   assign stop_req  = wr_take && (avs_address == `REG_CTRL) && avs_writedata[`CTRL_STOP];
   assign clr_conv  = wr_take && (avs_address == `REG_STATUS)
                      && avs_writedata[`STAT_CONV_ERR];
   assign clr_ovf   = wr_take && (avs_address == `REG_STATUS)
                      && avs_writedata[`STAT_OVF_ERR];

   // ---- conversion clock; the same event also serves the separate D/A sequencer
   conv_clock_gen u_clk (
      .clk         (clk),
      .rst_n       (rst_n),
      .src_sel     (src_ff),
      .div_reload  (div_ff),
      .ext_clk1    (ext_clk1),
      .ext_clk2    (ext_clk2),
      .frame_trig  (frame_trig),
      .tick        (tick),
      .frame_level (frame_level)
   );

   assign seq_tick = tick;

   // ---- event acceptance and run control
   always_comb begin
      any_seq = 1'b0;
      for (int i = 0; i < `NUM_ADC; i++) begin
         any_seq = any_seq | cfg_of(cfg_ff, i).seq;
      end
   end

   assign ev           = tick & run_ff & any_seq;
   assign conv_err_evt = ev & (state_ff != ST_IDLE);
   assign accept       = ev & (state_ff == ST_IDLE);
   assign is_final     = (nconv_ff != 16'h0000) && ((conv_cnt_ff + 16'h0001) == nconv_ff);

   // set wins over a software clear in the same cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         conv_err_ff <= 1'b0;
         ovf_err_ff  <= 1'b0;
      end else begin
         conv_err_ff <= conv_err_evt | (conv_err_ff & ~clr_conv);
         ovf_err_ff  <= ovf_evt | (ovf_err_ff & ~clr_ovf);
      end
   end

   // nconv of zero runs continuously; a start is refused while an error is pending
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         run_ff      <= 1'b0;
         conv_cnt_ff <= 16'h0000;
      end else if (conv_err_evt || ovf_evt || stop_req) begin
         run_ff <= 1'b0;
      end else if (accept) begin
         conv_cnt_ff <= conv_cnt_ff + 16'h0001;
         run_ff      <= ~is_final;
      end else if (start_req && !conv_err_ff && !ovf_err_ff) begin
         run_ff      <= 1'b1;
         conv_cnt_ff <= 16'h0000;
      end
   end

   // ---- per-device sampling
   always_comb begin
      max_cnt = 4'h0;
      for (int i = 0; i < `NUM_ADC; i++) begin
         if (cfg_of(lat_ff, i).seq && (eff_cnt(cfg_of(lat_ff, i)) > max_cnt)) begin
            max_cnt = eff_cnt(cfg_of(lat_ff, i));
         end
      end
   end

   genvar g;
   generate
      for (g = 0; g < `NUM_ADC; g++) begin : g_adc
         logic        done_q_ff;
         logic [15:0] smp_ff [`NUM_CH];
         logic        got;

         assign part_mask[g] = cfg_of(lat_ff, g).seq
                               && ({1'b0, ch_ff} < eff_cnt(cfg_of(lat_ff, g)));
         assign got = (state_ff == ST_WAIT) && part_mask[g] && adc_res[g].done;

         always_ff @(posedge clk) begin
            if (!rst_n || (state_ff == ST_CONV)) begin
               done_q_ff <= 1'b0;
            end else if (got) begin
               done_q_ff <= 1'b1;
            end
         end

         always_ff @(posedge clk) begin
            if (got) begin
               smp_ff[ch_ff] <= adc_res[g].data;
            end
         end

         assign done_v[g]   = done_q_ff;
         assign smp_word[g] = smp_ff[pc_ff];
         // channel and input mode reach the device from flops
         assign adc_ctl[g]  = adc_ctl_t'({cnv_ff[g], ch_ff, cfg_of(cfg_ff, g).diff});
      end
   endgenerate

   assign all_done = &(done_v | ~part_mask);

   // ---- push side of the data set
   assign cur         = cfg_of(lat_ff, int'(dev_ff));
   assign last_in_dev = ({1'b0, pc_ff} == (eff_cnt(cur) - 4'h1));
   assign later       = later_seq(lat_ff, dev_ff);
   assign push        = (state_ff == ST_PUSH) && cur.seq && !fifo_full;
   assign ovf_evt     = (state_ff == ST_PUSH) && cur.seq && fifo_full;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff <= ST_IDLE;
         ch_ff    <= 3'h0;
         dev_ff   <= 2'h0;
         pc_ff    <= 3'h0;
         final_ff <= 1'b0;
         lat_ff   <= 32'h0000_0000;
         cnv_ff   <= 4'h0;
      end else begin
         cnv_ff <= 4'h0;
         unique case (state_ff)
            ST_IDLE: begin
               if (accept) begin
                  lat_ff   <= cfg_ff;
                  final_ff <= is_final;
                  ch_ff    <= 3'h0;
                  state_ff <= ST_CONV;
               end
            end
            ST_CONV: begin
               // one pulse per channel per event, all devices in part_mask together
               cnv_ff   <= part_mask;
               state_ff <= ST_WAIT;
            end
            ST_WAIT: begin
               if (conv_err_evt) begin
                  state_ff <= ST_IDLE;
               end else if (all_done && (({1'b0, ch_ff} + 4'h1) < max_cnt)) begin
                  ch_ff    <= ch_ff + 3'h1;
                  state_ff <= ST_CONV;
               end else if (all_done) begin
                  dev_ff   <= 2'h0;
                  pc_ff    <= 3'h0;
                  state_ff <= ST_PUSH;
               end
            end
            ST_PUSH: begin
               if (conv_err_evt || ovf_evt) begin
                  state_ff <= ST_IDLE;
               end else if (!cur.seq || last_in_dev) begin
                  pc_ff <= 3'h0;
                  if (later) begin
                     dev_ff <= dev_ff + 2'h1;
                  end else begin
                     state_ff <= ST_IDLE;
                  end
               end else begin
                  pc_ff <= pc_ff + 3'h1;
               end
            end
         endcase
      end
   end

   // ---- data set FIFO toward the DMA write engine
   assign fifo_cnt   = wr_ptr_ff - rd_ptr_ff;
   assign fifo_full  = (fifo_cnt == `FIFO_FULL_LVL);
   assign fifo_valid = (fifo_cnt != 7'h00);
   assign fifo_word  = fifo_mem[rd_ptr_ff[`FIFO_AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         fifo_mem[wr_ptr_ff[`FIFO_AW-1:0]] <=
            '{last: final_ff & last_in_dev & ~later, data: smp_word[dev_ff]};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr_ff <= 7'h00;
         rd_ptr_ff <= 7'h00;
      end else begin
         if (push) begin
            wr_ptr_ff <= wr_ptr_ff + 7'h01;
         end
         if (fifo_valid && fifo_ready) begin
            rd_ptr_ff <= rd_ptr_ff + 7'h01;
         end
      end
   end

endmodule

/* hdl/conv_clock_gen.sv */
// Purpose: sequencer conversion clock event source, internal divider or rear inputs
// Assumes: rear inputs are asynchronous to clk
// Notes:   tick is a one-cycle pulse per conversion clock event
`timescale 1ns/100ps
`include "adc_seq_consts.svh"

module conv_clock_gen (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  src_sel,
   input  wire logic [15:0] div_reload,
   input  wire logic        ext_clk1,
   input  wire logic        ext_clk2,
   input  wire logic        frame_trig,
   output logic             tick,
   output logic             frame_level
);

   logic [15:0] div_cnt_ff;
   logic [2:0]  sync1_ff;
   logic [2:0]  sync2_ff;
   logic [2:0]  prev_ff;
   logic        tick_ff;
   logic        int_tick;
   logic [2:0]  rise;

   // period is div_reload+1 clocks
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_cnt_ff <= 16'h0000;
      end else if (div_cnt_ff == 16'h0000) begin
         div_cnt_ff <= div_reload;
      end else begin
         div_cnt_ff <= div_cnt_ff - 16'h0001;
      end
   end

   assign int_tick = (div_cnt_ff == 16'h0000);

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sync1_ff <= 3'h0;
         sync2_ff <= 3'h0;
         prev_ff  <= 3'h0;
      end else begin
         sync1_ff <= {frame_trig, ext_clk2, ext_clk1};
         sync2_ff <= sync1_ff;
         prev_ff  <= sync2_ff;
      end
   end

   assign rise = sync2_ff & ~prev_ff;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tick_ff <= 1'b0;
      end else begin
         unique case (src_sel)
            `SRC_INT:  tick_ff <= int_tick;
            `SRC_EXT1: tick_ff <= rise[0];
            `SRC_EXT2: tick_ff <= rise[1];
            default:   tick_ff <= 1'b0;
         endcase
      end
   end

   assign tick        = tick_ff;
   assign frame_level = sync2_ff[2];

endmodule

/* test/adc_model.sv */
// Purpose: behavioural multi-channel SAR converter on the far side
// Assumes: each cnv pulse is answered lat cycles later by one done pulse
// Notes: word is {dev, 0, chan, count of channel-0 pulses}
`timescale 1ns/100ps
module adc_model import adc_seq_pkg::*; #(
   parameter int DEV = 0
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic [2:0]            lat,
   input  wire adc_seq_pkg::adc_ctl_t ctl,
   output adc_seq_pkg::adc_res_t      res
);
   logic [2:0]  wait_ff;
   logic [2:0]  chan_ff;
   logic [7:0]  nev_ff;
   logic [15:0] last_ff;
   logic [15:0] word;
   assign word = {4'(DEV), 1'b0, chan_ff, nev_ff};
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wait_ff <= 3'h0;
         nev_ff  <= 8'h00;
         last_ff <= 16'h0000;
      end else if (ctl.cnv) begin
         wait_ff <= lat;
         chan_ff <= ctl.chan;
         if (ctl.chan == 3'h0) nev_ff <= nev_ff + 8'h01;
      end else if (wait_ff != 3'h0) begin
         wait_ff <= wait_ff - 3'h1;
      end
      if (res.done) last_ff <= word;
   end
   // idle bus shows the inverse of the last word so a stale capture cannot match
   assign res.done = (wait_ff == 3'h1);
   assign res.data = res.done ? word : ~last_ff;
endmodule

/* test/seq_gather_monitor.sv */
// Purpose: port-level checks of the A/D sequencer front end
// Assumes: one clock, synchronous active-low reset
// Notes: bound to adc_sequencer_gather at the foot
`timescale 1ns/100ps
`include "adc_seq_consts.svh"
module seq_gather_monitor import adc_seq_pkg::*; (
   input wire logic                   clk,
   input wire logic                   rst_n,
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic                   avs_waitrequest,
   input wire logic [1:0]             rear_pull_sel,
   input wire logic                   seq_tick,
   input wire adc_seq_pkg::adc_ctl_t  adc_ctl [`NUM_ADC],
   input wire adc_seq_pkg::adc_res_t  adc_res [`NUM_ADC],
   input wire logic                   fifo_valid,
   input wire logic                   fifo_ready,
   input wire adc_seq_pkg::seq_word_t fifo_word
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [2:0] prev_ch_ff;
   logic       busy0_ff;
   logic [3:0] since_tick_ff;
   always_ff @(posedge clk) begin
      if (!rst_n) prev_ch_ff <= 3'h0;
      else if (adc_ctl[0].cnv) prev_ch_ff <= adc_ctl[0].chan;
   end
   always_ff @(posedge clk) begin
      if (!rst_n) busy0_ff <= 1'b0;
      else if (adc_ctl[0].cnv) busy0_ff <= 1'b1;
      else if (adc_res[0].done) busy0_ff <= 1'b0;
   end
   // saturates so a stale tick never looks recent
   always_ff @(posedge clk) begin
      if (!rst_n) since_tick_ff <= 4'hF;
      else if (seq_tick) since_tick_ff <= 4'h0;
      else if (since_tick_ff != 4'hF) since_tick_ff <= since_tick_ff + 4'h1;
   end
   chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("long waitrequest");
   chk_wait_cause: assert property (avs_waitrequest |-> avs_read || avs_write)
      else $error("stray waitrequest");
   chk_cnv_pulse: assert property (adc_ctl[0].cnv |=> !adc_ctl[0].cnv)
      else $error("cnv longer than one cycle");
   chk_chan_asc: assert property (adc_ctl[0].cnv && adc_ctl[0].chan != 3'h0 |->
      prev_ch_ff == adc_ctl[0].chan - 3'h1) else $error("channel order broken");
   chk_same_chan: assert property (adc_ctl[0].cnv && adc_ctl[1].cnv |->
      adc_ctl[0].chan == adc_ctl[1].chan) else $error("devices not in step");
   chk_done_first: assert property (adc_ctl[0].cnv |-> !busy0_ff)
      else $error("cnv before previous result");
   chk_tick_start: assert property (adc_ctl[0].cnv && adc_ctl[0].chan == 3'h0 |->
      since_tick_ff <= 4'h3) else $error("set started without a tick");
   chk_fifo_hold: assert property (fifo_valid && !fifo_ready |=>
      fifo_valid && $stable(fifo_word)) else $error("head moved in stall");
   chk_pull_hold: assert property (!(avs_write && !avs_waitrequest) |=>
      $stable(rear_pull_sel)) else $error("pull moved unwritten");
   chk_diff_four: assert property (adc_ctl[0].cnv && adc_ctl[0].diff |->
      adc_ctl[0].chan <= 3'h3) else $error("diff channel above 3");
   cov_last: cover property (fifo_valid && fifo_ready && fifo_word.last);
   cov_ch7: cover property (adc_ctl[0].cnv && adc_ctl[0].chan == 3'h7);
   cov_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind adc_sequencer_gather seq_gather_monitor i_seq_gather_monitor (
   .clk(clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .rear_pull_sel(rear_pull_sel), .seq_tick(seq_tick),
   .adc_ctl(adc_ctl), .adc_res(adc_res), .fifo_valid(fifo_valid), .fifo_ready(fifo_ready),
   .fifo_word(fifo_word)
);

/* test/tb_top.sv */
// Purpose: self-checking bench of the A/D sequencer front end
// Assumes: four converter models answer after a random latency
// Notes: expected sets are rebuilt from configuration and model counts
`timescale 1ns/100ps
`include "adc_seq_consts.svh"
module tb_top;
   import adc_seq_pkg::*;
   logic        clk = 0, rst_n = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
   logic [7:0]  avs_address = 0;
   logic [31:0] avs_writedata = 0, avs_readdata, rd, c0, cnv_seen = 0;
   logic        ext_clk1 = 0, ext_clk2 = 0, frame_trig = 0, ext_en = 0;
   logic        seq_tick, fifo_valid, fifo_ready = 0, rdy_en = 0;
   logic [1:0]  rear_pull_sel;
   logic [2:0]  lat = 3'h2;
   logic [8:0]  ext_div = 0;
   adc_ctl_t    adc_ctl [`NUM_ADC];
   adc_res_t    adc_res [`NUM_ADC];
   seq_word_t   fifo_word, got[$], exp[$];
   int          fail_count = 0, samples_checked = 0, nev [`NUM_ADC] = '{default: 0};

   always #12.5 clk = ~clk;

   adc_sequencer_gather i_adc_sequencer_gather (.clk(clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ext_clk1(ext_clk1), .ext_clk2(ext_clk2),
      .frame_trig(frame_trig), .rear_pull_sel(rear_pull_sel), .seq_tick(seq_tick),
      .adc_ctl(adc_ctl), .adc_res(adc_res), .fifo_valid(fifo_valid),
      .fifo_ready(fifo_ready), .fifo_word(fifo_word));
   for (genvar i = 0; i < `NUM_ADC; i++) begin : g_adc
      adc_model #(.DEV(i)) i_adc_model (.clk(clk), .rst_n(rst_n), .lat(lat),
         .ctl(adc_ctl[i]), .res(adc_res[i]));
   end

   // random ready stalls the drain; external clock events every 512 cycles
   always @(posedge clk) begin
      if (fifo_valid && fifo_ready) got.push_back(fifo_word);
      if (adc_ctl[0].cnv) cnv_seen <= cnv_seen + 1;
      fifo_ready <= rdy_en && ($urandom_range(3) != 0);
      ext_div    <= ext_div + 9'h001;
      ext_clk1   <= ext_en && ext_div[8];
      ext_clk2   <= ext_div[8];
   end

   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      avs_read      <= !wr;
      avs_write     <= wr;
      avs_address   <= a;
      avs_writedata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest && n < 50);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) fail_count++;
   endtask

   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e, input string what);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t %s got %h exp %h", $time, what, g, e);
      end
   endtask

   task automatic chk_word(input seq_word_t g, input seq_word_t e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR t=%0t word got %h exp %h", $time, g, e);
      end
   endtask

   function automatic seq_word_t exp_word(int dev, int ch, int n);
      return seq_word_t'({1'b0, 4'(dev), 1'b0, 3'(ch), 8'(n)});
   endfunction

   task automatic gather(input logic [3:0] seqm, input int nconv, input logic [1:0] src);
      logic [31:0] cfg;
      int          cnt [`NUM_ADC];
      int          n;
      cfg = 32'h0000_0000;
      for (int i = 0; i < `NUM_ADC; i++) begin
         cnt[i] = $urandom_range(1, 8);
         cfg[i*8+:5] = {3'(cnt[i] - 1), 1'($urandom_range(1)), seqm[i]};
         if (cfg[i*8+1] && cnt[i] > 4) cnt[i] = 4;
      end
      bus(1'b1, `REG_ADC_CFG, cfg);
      bus(1'b1, `REG_NCONV, 32'(nconv));
      bus(1'b1, `REG_CTRL, {26'h0, 2'h3, src, 2'h1});
      for (int e = 1; e <= nconv; e++)
         for (int i = 0; i < `NUM_ADC; i++)
            for (int c = 0; c < cnt[i] && seqm[i]; c++) exp.push_back(exp_word(i, c, nev[i] + e));
      exp[exp.size()-1].last = 1'b1;
      for (int i = 0; i < `NUM_ADC; i++) if (seqm[i]) nev[i] += nconv;
      n = 0;
      do begin
         bus(1'b0, `REG_STATUS, 0);
         n++;
      end while ((rd[0] || rd[3]) && n < 1000);
      n = 0;
      while (got.size() < exp.size() && n < 2000) begin
         @(posedge clk);
         n++;
      end
      chk_reg(32'(got.size()), 32'(exp.size()), "set size");
      foreach (exp[k]) if (k < got.size()) chk_word(got[k], exp[k]);
      chk_reg({30'h0, rear_pull_sel}, 32'h0000_0003, "pull");
      got.delete();
      exp.delete();
   endtask

   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #1_500_000;
      fail_count++;
      print_verdict();
   end

   initial begin
      void'($urandom(29));
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      bus(1'b0, `REG_DIV, 0);
      chk_reg(rd, 32'h0000_0031, "div reset");
      bus(1'b1, `REG_DIV, 32'h0000_018F);
      bus(1'b0, `REG_DIV, 0);
      chk_reg(rd, 32'h0000_018F, "div");
      bus(1'b0, 8'h1C, 0);
      chk_reg(rd, 32'h0000_0000, "unmapped");
      rdy_en <= 1'b1;
      gather(4'h8, 1, `SRC_INT);
      for (int r = 0; r < 3; r++) begin
         lat <= 3'($urandom_range(1, 4));
         gather(4'($urandom_range(1, 15)), 3, r[1] ? `SRC_EXT2 : `SRC_INT);
      end
      ext_en <= 1'b1;
      gather(4'h5, 2, `SRC_EXT1);
      ext_en <= 1'b0;
      // no device in sequencer mode: events must pass unnoticed
      bus(1'b1, `REG_DIV, 32'h0000_0009);
      bus(1'b1, `REG_ADC_CFG, 0);
      bus(1'b1, `REG_CTRL, 32'h0000_0031);
      c0 = cnv_seen;
      repeat (300) @(posedge clk);
      chk_reg(cnv_seen, c0, "no seq pulses");
      chk_reg(32'(got.size()), 0, "no seq words");
      bus(1'b1, `REG_CTRL, 32'h0000_0032);
      // events every 10 cycles against eight slow channels overrun the set
      lat <= 3'h7;
      bus(1'b1, `REG_ADC_CFG, 32'h1D1D_1D1D);
      bus(1'b1, `REG_NCONV, 0);
      bus(1'b1, `REG_CTRL, 32'h0000_0031);
      c0 = 0;
      do begin
         bus(1'b0, `REG_STATUS, 0);
         c0++;
      end while (!rd[1] && c0 < 200);
      chk_reg(rd & 32'h0000_0007, 32'h0000_0002, "conv error");
      repeat (20) @(posedge clk);
      c0 = cnv_seen;
      repeat (100) @(posedge clk);
      chk_reg(cnv_seen, c0, "stopped");
      bus(1'b1, `REG_STATUS, 32'h0000_0006);
      bus(1'b0, `REG_STATUS, 0);
      chk_reg(rd & 32'h0000_0006, 32'h0000_0000, "w1c");
      print_verdict();
   end
endmodule
